//--- common/pcrl_pkg.sv
/*
 * Constants for the personal-code check and retry logic: register map,
 * command fields, command lengths, counter start values and status words.
 * Assumes one 100 MHz clock and a plain strobe register port.
 */
// Behaviour
// - Verify compares only when enabled and unblocked
// - Correct verify restores attempt counter to 3
// - Wrong verify decrements the one shared counter
// - First wrong presentation answers 63C2
// - Second wrong answers 63C1; counter persists
// - Third wrong blocks code and answers 63C0
// - Verify with data on blocked code gives 6983
// - Security status holds on every logical channel
// - Code-guarded function allowed if verified or disabled
// - Empty verify returns 63CX with remaining count
// - Empty verify on blocked code gives 63C0
// - P2 low five bits select reference 01-1F
// - P2 top bit selects global or specific set
// - Change accepted only when enabled and unblocked
// - Correct old code installs new, counter 3
// - Wrong old code decrements, value kept, blocks
// - Changed code takes effect for all channels
// - Correct unblock installs code, counters 10 and 3
package pcrl_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADR_CMD = 8'h00;
    localparam logic [7:0] ADR_DATA0 = 8'h04;
    localparam logic [7:0] ADR_DATA1 = 8'h08;
    localparam logic [7:0] ADR_DATA2 = 8'h0C;
    localparam logic [7:0] ADR_DATA3 = 8'h10;
    localparam logic [7:0] ADR_STATUS = 8'h14;
    localparam logic [7:0] ADR_SEC_LO = 8'h18;
    localparam logic [7:0] ADR_SEC_HI = 8'h1C;
    localparam logic [7:0] ADR_ACC = 8'h20;

    // ------------------------------------------------------------------
    // Command, status and access register fields
    // ------------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_P2_LSB = 8;
    localparam int CMD_LC_LSB = 16;
    localparam int CMD_DIS_BIT = 24;
    localparam int STAT_BUSY_BIT = 16;
    localparam int ACC_GRANT_BIT = 8;
    localparam logic [31:0] CMD_RESET = 32'h0000_0000;

    // Operation codes
    localparam logic [2:0] OP_VERIFY = 3'h0;
    localparam logic [2:0] OP_CHANGE = 3'h1;
    localparam logic [2:0] OP_UNBLOCK = 3'h2;
    localparam logic [2:0] OP_PERSO = 3'h3;

    // Data field lengths
    localparam logic [7:0] LC_NONE = 8'h00;
    localparam logic [7:0] LC_CODE = 8'h08;
    localparam logic [7:0] LC_PAIR = 8'h10;

    // Counter start values
    localparam logic [1:0] CNT_INIT = 2'h3;
    localparam logic [3:0] UCNT_INIT = 4'hA;

    // ------------------------------------------------------------------
    // Status words
    // ------------------------------------------------------------------
    localparam logic [15:0] SW_OK = 16'h9000;
    localparam logic [15:0] SW_RETRY = 16'h63C0;
    localparam logic [15:0] SW_BLOCKED = 16'h6983;
    localparam logic [15:0] SW_UNUSABLE = 16'h6984;
    localparam logic [15:0] SW_BAD_LEN = 16'h6700;
    localparam logic [15:0] SW_BAD_P2 = 16'h6A86;
    localparam logic [15:0] SW_BAD_INS = 16'h6D00;
    localparam logic [15:0] SW_RESET = 16'h0000;

    // Command sequencer states
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_EXEC
    } pcrl_state_t;

endpackage : pcrl_pkg

//--- verilog/pcrl_ref_store.sv
/*
 * Reference store: one code, unblock key, attempt counter, unblock
 * counter, blocked flag and disabled flag per reference (64 entries).
 * Models non-volatile memory: not cleared by reset, must be personalised.
 */
`timescale 1ns/1ps
`default_nettype none

module pcrl_ref_store
    import pcrl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_we,
    input wire logic [5:0] i_widx,
    input wire logic [63:0] i_code,
    input wire logic [63:0] i_ukey,
    input wire logic [1:0] i_cnt,
    input wire logic [3:0] i_ucnt,
    input wire logic i_blocked,
    input wire logic i_disabled,
    input wire logic [5:0] i_ridx,
    output logic [63:0] o_code,
    output logic [63:0] o_ukey,
    output logic [1:0] o_cnt,
    output logic [3:0] o_ucnt,
    output logic o_blocked,
    output logic o_disabled,
    input wire logic [5:0] i_ridx_b,
    output logic o_disabled_b
);

    // ------------------------------------------------------------------
    // Storage arrays
    // ------------------------------------------------------------------
    logic [63:0] code_m [64]; // Reference code values
    logic [63:0] ukey_m [64]; // Unblock key values
    logic [1:0] cnt_m [64]; // Remaining code attempts
    logic [3:0] ucnt_m [64]; // Remaining unblock attempts
    logic [63:0] blk_m; // Blocked flags
    logic [63:0] dis_m; // Disabled flags

    // One write updates a whole entry at once
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            code_m[i_widx] <= i_code;
            ukey_m[i_widx] <= i_ukey;
            cnt_m[i_widx] <= i_cnt;
            ucnt_m[i_widx] <= i_ucnt;
            blk_m[i_widx] <= i_blocked;
            dis_m[i_widx] <= i_disabled;
        end
    end

    // Combinational read ports
    assign o_code = code_m[i_ridx];
    assign o_ukey = ukey_m[i_ridx];
    assign o_cnt = cnt_m[i_ridx];
    assign o_ucnt = ucnt_m[i_ridx];
    assign o_blocked = blk_m[i_ridx];
    assign o_disabled = dis_m[i_ridx];
    assign o_disabled_b = dis_m[i_ridx_b];

endmodule : pcrl_ref_store

`default_nettype wire

//--- verilog/pcrl_top.sv
/*
 * Personal-code command interpreter: verify, change, unblock and
 * personalise, with shared retry counters and session security status.
 * Assumes a plain strobe register port synchronous to I_SYS_CLK.
 */
`timescale 1ns/1ps
`default_nettype none

module pcrl_top
    import pcrl_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    output logic O_BUSY,
    output logic O_DONE
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    pcrl_state_t state_q; // Sequencer state
    logic [31:0] cmd_q; // Command register
    logic [31:0] data_q [4]; // Command data, bytes 1..16
    logic [15:0] sw_q; // Last status word
    logic [63:0] sec_q; // Security status, all channels
    logic [5:0] acc_idx_q; // Reference for access query
    logic [31:0] rdata_q; // Read data
    logic done_q; // Completion pulse

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire logic wr_cmd = I_WR && (I_ADDR == ADR_CMD);
    wire logic wr_acc = I_WR && (I_ADDR == ADR_ACC);
    wire logic launch = wr_cmd && (state_q == ST_IDLE);
    wire logic exec = (state_q == ST_EXEC);
    wire logic [2:0] op = cmd_q[CMD_OP_LSB +: 3];
    wire logic [7:0] p2 = cmd_q[CMD_P2_LSB +: 8];
    wire logic [7:0] lc = cmd_q[CMD_LC_LSB +: 8];
    wire logic [5:0] idx = {p2[7], p2[4:0]};
    wire logic p2_bad = (p2[6:5] != 2'h0) || (p2[4:0] == 5'h00);
    wire logic [63:0] val_a = {data_q[0], data_q[1]};
    wire logic [63:0] val_b = {data_q[2], data_q[3]};

    // Store read side
    logic [63:0] rd_code;
    logic [63:0] rd_ukey;
    logic [1:0] rd_cnt;
    logic [3:0] rd_ucnt;
    logic rd_blk;
    logic rd_dis;
    logic acc_dis;

    wire logic code_ok = (rd_code == val_a);
    wire logic ukey_ok = (rd_ukey == val_a);
    wire logic [1:0] cnt_dec = rd_cnt - 2'h1;
    wire logic [3:0] ucnt_dec = rd_ucnt - 4'h1;

    // ------------------------------------------------------------------
    // Command execution
    // ------------------------------------------------------------------
    logic we_c; // Entry write request
    logic [63:0] w_code;
    logic [63:0] w_ukey;
    logic [1:0] w_cnt;
    logic [3:0] w_ucnt;
    logic w_blk;
    logic w_dis;
    logic [15:0] sw_c; // Status word produced
    logic sec_set_c; // Grant security status
    logic sec_clr_c; // Revoke security status

    // Outcome of the latched command against the addressed entry
    always_comb begin
        we_c = 1'b0;
        w_code = rd_code;
        w_ukey = rd_ukey;
        w_cnt = rd_cnt;
        w_ucnt = rd_ucnt;
        w_blk = rd_blk;
        w_dis = rd_dis;
        sw_c = SW_OK;
        sec_set_c = 1'b0;
        sec_clr_c = 1'b0;
        if (p2_bad && (op != OP_PERSO)) begin
            // Reserved or zero reference qualifier
            sw_c = SW_BAD_P2;
        end else begin
            case (op)
                OP_VERIFY: begin
                    if (lc == LC_NONE) begin
                        // Retry count query; blocked reads 63C0
                        sw_c = SW_RETRY | {14'h0000, rd_cnt};
                    end else if (lc != LC_CODE) begin
                        sw_c = SW_BAD_LEN;
                    end else if (rd_blk) begin
                        sw_c = SW_BLOCKED;
                    end else if (rd_dis) begin
                        sw_c = SW_UNUSABLE;
                    end else if (code_ok) begin
                        we_c = 1'b1;
                        w_cnt = CNT_INIT;
                        sec_set_c = 1'b1;
                    end else begin
                        // Wrong code: 3 -> 63C2, 2 -> 63C1, 1 -> block
                        we_c = 1'b1;
                        w_cnt = cnt_dec;
                        w_blk = (cnt_dec == 2'h0);
                        sec_clr_c = (cnt_dec == 2'h0);
                        sw_c = SW_RETRY | {14'h0000, cnt_dec};
                    end
                end
                OP_CHANGE: begin
                    if (lc != LC_PAIR) begin
                        sw_c = SW_BAD_LEN;
                    end else if (rd_blk) begin
                        sw_c = SW_BLOCKED;
                    end else if (rd_dis) begin
                        sw_c = SW_UNUSABLE;
                    end else if (code_ok) begin
                        we_c = 1'b1;
                        w_code = val_b;
                        w_cnt = CNT_INIT;
                    end else begin
                        // Value kept, counter steps down
                        we_c = 1'b1;
                        w_cnt = cnt_dec;
                        w_blk = (cnt_dec == 2'h0);
                        sec_clr_c = (cnt_dec == 2'h0);
                        sw_c = SW_RETRY | {14'h0000, cnt_dec};
                    end
                end
                OP_UNBLOCK: begin
                    if (lc != LC_PAIR) begin
                        sw_c = SW_BAD_LEN;
                    end else if (rd_ucnt == 4'h0) begin
                        // Unblock key itself exhausted
                        sw_c = SW_BLOCKED;
                    end else if (ukey_ok) begin
                        we_c = 1'b1;
                        w_code = val_b;
                        w_cnt = CNT_INIT;
                        w_ucnt = UCNT_INIT;
                        w_blk = 1'b0;
                        w_dis = 1'b0;
                        sec_set_c = 1'b1;
                    end else begin
                        we_c = 1'b1;
                        w_ucnt = ucnt_dec;
                        sw_c = SW_RETRY | {12'h000, ucnt_dec};
                    end
                end
                OP_PERSO: begin
                    // Loads code and unblock key into the entry
                    if (lc != LC_PAIR || p2_bad) begin
                        sw_c = (lc != LC_PAIR) ? SW_BAD_LEN : SW_BAD_P2;
                    end else begin
                        we_c = 1'b1;
                        w_code = val_a;
                        w_ukey = val_b;
                        w_cnt = CNT_INIT;
                        w_ucnt = UCNT_INIT;
                        w_blk = 1'b0;
                        w_dis = cmd_q[CMD_DIS_BIT];
                        sec_clr_c = 1'b1;
                    end
                end
                default: begin
                    sw_c = SW_BAD_INS;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Reference store
    // ------------------------------------------------------------------
    pcrl_ref_store u_store (
        .i_clk(I_SYS_CLK),
        .i_we(we_c && exec),
        .i_widx(idx),
        .i_code(w_code),
        .i_ukey(w_ukey),
        .i_cnt(w_cnt),
        .i_ucnt(w_ucnt),
        .i_blocked(w_blk),
        .i_disabled(w_dis),
        .i_ridx(idx),
        .o_code(rd_code),
        .o_ukey(rd_ukey),
        .o_cnt(rd_cnt),
        .o_ucnt(rd_ucnt),
        .o_blocked(rd_blk),
        .o_disabled(rd_dis),
        .i_ridx_b(acc_idx_q),
        .o_disabled_b(acc_dis)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Command write starts one execution cycle
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state_q <= ST_IDLE;
            done_q <= 1'b0;
        end else begin
            done_q <= exec;
            case (state_q)
                ST_IDLE: begin
                    if (launch) begin
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Command register, ignored while executing
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            cmd_q <= CMD_RESET;
        end else if (launch) begin
            cmd_q <= I_WDATA;
        end
    end

    // Data registers, one per word
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_data
            localparam logic [7:0] ADR_W = ADR_DATA0 + 8'(gi * 4);
            always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
                if (I_SYS_RST) begin
                    data_q[gi] <= 32'h0000_0000;
                end else if (I_WR && (I_ADDR == ADR_W)) begin
                    data_q[gi] <= I_WDATA;
                end
            end
        end
    endgenerate

    // Status word from the finished command
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            sw_q <= SW_RESET;
        end else if (exec) begin
            sw_q <= sw_c;
        end
    end

    // Security status shared by all channels; set wins over clear
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            sec_q <= 64'h0000_0000_0000_0000;
        end else if (exec && sec_set_c) begin
            sec_q[idx] <= 1'b1;
        end else if (exec && sec_clr_c) begin
            sec_q[idx] <= 1'b0;
        end
    end

    // Access query reference
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            acc_idx_q <= 6'h00;
        end else if (wr_acc) begin
            acc_idx_q <= I_WDATA[5:0];
        end
    end

    // ------------------------------------------------------------------
    // Read side
    // ------------------------------------------------------------------
    wire logic grant = sec_q[acc_idx_q] | acc_dis;
    logic [31:0] rd_mux;

    // Read data selection; unmapped reads give zero
    always_comb begin
        case (I_ADDR)
            ADR_CMD: rd_mux = cmd_q;
            ADR_DATA0: rd_mux = data_q[0];
            ADR_DATA1: rd_mux = data_q[1];
            ADR_DATA2: rd_mux = data_q[2];
            ADR_DATA3: rd_mux = data_q[3];
            ADR_STATUS: rd_mux = {15'h0000, exec, sw_q};
            ADR_SEC_LO: rd_mux = sec_q[31:0];
            ADR_SEC_HI: rd_mux = sec_q[63:32];
            ADR_ACC: rd_mux = {23'h000000, grant, 2'h0, acc_idx_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data stands one cycle after the strobe
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            rdata_q <= 32'h0000_0000;
        end else if (I_RD) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign O_RDATA = rdata_q;
    assign O_BUSY = exec;
    assign O_DONE = done_q;

endmodule : pcrl_top

`default_nettype wire

//--- dv/pcrl_assertions.sv
/*
 * Checker for the code-check block: command, bus and read timing.
 * Assumes one clock, async high reset and the package constants.
 */
`timescale 1ns/1ps
`default_nettype none

module pcrl_assertions
    import pcrl_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [31:0] O_RDATA,
    input wire logic O_BUSY,
    input wire logic O_DONE
);
    // ------------------------------------------------------------
    // Clocking and decodes
    // ------------------------------------------------------------
    default clocking dc @(posedge I_SYS_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    // Strobes aimed at single registers
    wire logic cmd_wr = I_WR && (I_ADDR == ADR_CMD);
    wire logic acc_wr = I_WR && (I_ADDR == ADR_ACC);
    wire logic acc_rd = I_RD && (I_ADDR == ADR_ACC);
    wire logic st_rd = I_RD && (I_ADDR == ADR_STATUS);
    // Command taken while idle
    sequence s_take;
        cmd_wr && !O_BUSY;
    endsequence
    // Execution cycle, then completion pulse
    sequence s_exec;
        O_BUSY ##1 (O_DONE && !O_BUSY);
    endsequence
    // Index write, one quiet cycle, index read
    sequence s_acc_rw;
        acc_wr ##1 !I_WR ##1 acc_rd;
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_cmd_exec: assert property (s_take |=> s_exec)
        else $error("no busy then done");
    a_busy_cause: assert property (
        O_BUSY |-> $past(cmd_wr) && !$past(O_BUSY))
        else $error("busy without command");
    a_done_cause: assert property (O_DONE |-> $past(O_BUSY))
        else $error("done without busy");
    a_refuse_busy: assert property (O_BUSY && cmd_wr |=> !O_BUSY)
        else $error("command taken during busy");
    a_rdata_quiet: assert property (
        !$past(I_RD) |-> O_RDATA == 32'h0000_0000)
        else $error("stray read data");
    a_unmapped_zero: assert property (
        I_RD && I_ADDR > ADR_ACC |=> O_RDATA == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_acc_index: assert property (
        s_acc_rw |=> O_RDATA[5:0] == $past(I_WDATA[5:0], 3))
        else $error("index read back wrong");
    a_status_busy: assert property (
        st_rd |=> O_RDATA[STAT_BUSY_BIT] == $past(O_BUSY))
        else $error("status busy bit wrong");
endmodule : pcrl_assertions

bind pcrl_top pcrl_assertions i_pcrl_assertions (
    .I_SYS_CLK(I_SYS_CLK), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
    .O_BUSY(O_BUSY), .O_DONE(O_DONE)
);

`default_nettype wire

//--- dv/pcrl_term_model.sv
/*
 * Terminal model: sends command words and data fields over the
 * register port. Assumes the bench calls its tasks after a clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module pcrl_term_model
    import pcrl_pkg::*;
(
    input wire logic i_clk,
    output logic [7:0] o_addr,
    output logic [31:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    input wire logic [31:0] i_rdata
);
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Quiet bus at time zero
    initial begin
        o_addr = 8'h00;
        o_wdata = 32'h0000_0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    // One write; released lines flip so stale values never match
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask : wr
    // Two writes with no gap, the second in the busy cycle
    task automatic wr2(input logic [7:0] a, input logic [31:0] d1,
                       input logic [31:0] d2);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d1;
        wr(a, d2);
    endtask : wr2
    // One read; data taken in the cycle where it stands
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
    endtask : rd
    // Command word from operation, reference qualifier and length
    function automatic logic [31:0] cw(input logic [2:0] op,
        input logic [7:0] p2, input logic [7:0] lc, input logic dis);
        return {7'h00, dis, lc, p2, 5'h00, op};
    endfunction : cw
    // Data field: old value (bytes 1..8), then new value (9..16)
    task automatic ld(input logic [63:0] a, input logic [63:0] b);
        wr(ADR_DATA0, a[63:32]);
        wr(ADR_DATA1, a[31:0]);
        wr(ADR_DATA2, b[63:32]);
        wr(ADR_DATA3, b[31:0]);
    endtask : ld
endmodule : pcrl_term_model

`default_nettype wire

//--- dv/pcrl_tb_top.sv
/*
 * Bench for the code-check block: each scenario runs commands through
 * the terminal model and judges status words. Assumes a 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pcrl_tb_top;
    import pcrl_pkg::*;
    // ------------------------------------------------------------
    // Codes, clock, reset and wiring
    // ------------------------------------------------------------
    localparam logic [63:0] CA = 64'h1234_5678_9ABC_DEF0;
    localparam logic [63:0] CB = 64'h0F1E_2D3C_4B5A_6978;
    localparam logic [63:0] CN = 64'h5555_AAAA_5555_AAAA;
    localparam logic [63:0] CK = 64'hC0DE_C0DE_0BAD_F00D;
    localparam logic [63:0] CW = 64'h1;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic dis = 1'b0;
    int fail_count = 0;
    int total_checks = 0;
    wire logic [7:0] addr;
    wire logic [31:0] wdata;
    wire logic [31:0] rdata;
    wire logic wr;
    wire logic rd;
    wire logic busy;
    wire logic done;
    // 100 MHz clock
    always #5 clk = ~clk;
    pcrl_top i_pcrl_top (.I_SYS_CLK(clk), .I_SYS_RST(rst),
        .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdata), .O_BUSY(busy), .O_DONE(done));
    pcrl_term_model i_pcrl_term_model (.i_clk(clk), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .i_rdata(rdata));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        i_pcrl_term_model.rd(a, d);
        chk(d, e);
    endtask : rdc
    // Bounded wait for done, then judge the status word
    task automatic fin(input logic [15:0] e);
        int n;
        #1;
        n = 0;
        while (done !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (done !== 1'b1) begin
            fail_count++;
            $display("BAD %0t no completion", $time);
            end_sim();
        end
        rdc(ADR_STATUS, {16'h0000, e});
    endtask : fin
    task automatic ex(input logic [63:0] a, b, input logic [2:0] op,
                      input logic [7:0] p2, lc, input logic [15:0] e);
        i_pcrl_term_model.ld(a, b);
        i_pcrl_term_model.wr(ADR_CMD, i_pcrl_term_model.cw(op, p2, lc,
                                                            dis));
        fin(e);
    endtask : ex
    // Mid-run reset; the reference store must survive it
    task automatic rst_pulse();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask : rst_pulse
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_perso();
        ex(CA, CK, OP_PERSO, 8'h01, LC_PAIR, SW_OK);
        ex(CN, CK, OP_PERSO, 8'h81, LC_PAIR, SW_OK);
        dis = 1'b1;
        ex(CA, CK, OP_PERSO, 8'h02, LC_PAIR, SW_OK);
        dis = 1'b0;
    endtask : t_perso
    task automatic t_ok();
        ex(CW, CW, OP_VERIFY, 8'h01, LC_NONE, 16'h63C3);
        ex(CA, CW, OP_VERIFY, 8'h01, LC_CODE, SW_OK);
        rdc(ADR_SEC_LO, 32'h2);
        i_pcrl_term_model.wr(ADR_ACC, 32'h1);
        rdc(ADR_ACC, 32'h101);
    endtask : t_ok
    task automatic t_wrong();
        ex(CW, CW, OP_VERIFY, 8'h01, LC_CODE, 16'h63C2);
        ex(CW, CW, OP_VERIFY, 8'h01, LC_CODE, 16'h63C1);
        ex(CW, CW, OP_VERIFY, 8'h01, LC_CODE, 16'h63C0);
        rdc(ADR_ACC, 32'h1);
        rst_pulse();
        ex(CW, CW, OP_VERIFY, 8'h01, LC_NONE, 16'h63C0);
    endtask : t_wrong
    task automatic t_blk();
        ex(CA, CN, OP_VERIFY, 8'h01, LC_CODE, SW_BLOCKED);
        ex(CA, CN, OP_CHANGE, 8'h01, LC_PAIR, SW_BLOCKED);
        ex(CW, CN, OP_UNBLOCK, 8'h01, LC_PAIR, 16'h63C9);
        ex(CK, CN, OP_UNBLOCK, 8'h01, LC_PAIR, SW_OK);
        ex(CW, CW, OP_VERIFY, 8'h01, LC_NONE, 16'h63C3);
        rdc(ADR_SEC_LO, 32'h2);
        ex(CW, CN, OP_UNBLOCK, 8'h01, LC_PAIR, 16'h63C9);
    endtask : t_blk
    task automatic t_chg();
        ex(CA, CB, OP_CHANGE, 8'h01, LC_PAIR, 16'h63C2);
        ex(CN, CB, OP_VERIFY, 8'h01, LC_CODE, SW_OK);
        ex(CN, CB, OP_CHANGE, 8'h01, LC_PAIR, SW_OK);
        ex(CN, CB, OP_VERIFY, 8'h01, LC_CODE, 16'h63C2);
        ex(CB, CW, OP_VERIFY, 8'h01, LC_CODE, SW_OK);
        ex(CW, CW, OP_VERIFY, 8'h01, LC_CODE, 16'h63C2);
        rst_pulse();
        ex(CW, CW, OP_VERIFY, 8'h01, LC_NONE, 16'h63C2);
        ex(CB, CW, OP_VERIFY, 8'h01, LC_CODE, SW_OK);
    endtask : t_chg
    task automatic t_p2();
        ex(CW, CW, OP_VERIFY, 8'h00, LC_NONE, SW_BAD_P2);
        ex(CW, CW, OP_VERIFY, 8'h41, LC_NONE, SW_BAD_P2);
        ex(CW, CW, OP_VERIFY, 8'h21, LC_NONE, SW_BAD_P2);
        ex(CB, CW, OP_VERIFY, 8'h81, LC_CODE, 16'h63C2);
        ex(CN, CW, OP_VERIFY, 8'h81, LC_CODE, SW_OK);
        rdc(ADR_SEC_HI, 32'h2);
        ex(CW, CW, OP_CHANGE, 8'h01, LC_CODE, SW_BAD_LEN);
        ex(CW, CW, 3'h7, 8'h01, LC_NONE, SW_BAD_INS);
    endtask : t_p2
    task automatic t_dis();
        ex(CA, CB, OP_VERIFY, 8'h02, LC_CODE, SW_UNUSABLE);
        ex(CA, CB, OP_CHANGE, 8'h02, LC_PAIR, SW_UNUSABLE);
        ex(CW, CW, OP_VERIFY, 8'h02, LC_NONE, 16'h63C3);
        i_pcrl_term_model.wr(ADR_ACC, 32'h2);
        rdc(ADR_ACC, 32'h102);
    endtask : t_dis
    // Unmapped read; empty verify of 01, then op 7 refused while busy
    task automatic t_bus();
        rdc(8'h24, 32'h0);
        i_pcrl_term_model.wr2(ADR_CMD, 32'h100, 32'h107);
        fin(16'h63C3);
    endtask : t_bus
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_perso();
        t_ok();
        t_wrong();
        t_blk();
        t_chg();
        t_p2();
        t_dis();
        t_bus();
        end_sim();
    end
endmodule : pcrl_tb_top

`default_nettype wire
